// File: hw/tfel_error_logic.sv
// Purpose: error detection, classing and reporting of a tape formatter
// Assumes: event inputs are one-cycle pulses from the formatter datapath
// Notes:   exception is a level until the next clear, end-of-block until the next go command or clear
`timescale 1ns/1ps
`default_nettype none
module tfel_error_logic #(
  parameter logic [31:0] EXIST_MASK  = tfel_pkg::REG_EXIST_MASK,
  parameter logic [31:0] FUNC_MASK   = tfel_pkg::FUNC_VALID_MASK,
  parameter logic [15:0] FORMAT_MASK = tfel_pkg::FORMAT_VALID_MASK
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        controller_init,
  // drive register port
  input  wire logic        drive_selected,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_read,
  input  wire logic        reg_write,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wparity,
  output logic             reg_write_accept,
  output logic [15:0]      reg_rdata,
  // transfer control from the datapath
  input  wire logic        transfer_start,
  input  wire logic [3:0]  format_code,
  input  wire logic        write_mode,
  input  wire logic        block_end,
  input  wire logic        op_done,
  // write data parity
  input  wire logic        data_valid,
  input  wire logic [15:0] data_word,
  input  wire logic        data_parity,
  // recording quality events
  input  wire logic        pe_mode,
  input  wire logic        uncorrectable_event,
  input  wire logic        vertical_parity_event,
  input  wire logic        late_data_event,
  input  wire logic        preamble_error_event,
  input  wire logic        lrc_check,
  input  wire logic [7:0]  longitudinal_check_character,
  input  wire logic [7:0]  computed_check_character,
  // gap and frame count events
  input  wire logic        gap_char_event,
  input  wire logic        shutdown_first_half,
  input  wire logic        space_end,
  input  wire logic        frame_count_nonzero,
  input  wire logic        frame_count_overflow,
  input  wire logic        word_count_overflowed,
  input  wire logic        record_end,
  // reporting
  output logic             exception_signal,
  output logic             end_of_block_signal,
  output logic             stop_transfer,
  output logic             operation_busy,
  output logic [15:0]      error_flags,
  output logic             drive_status_error
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // odd parity over word and parity bit
  function automatic logic parity_ok(input logic [15:0] word, input logic par);
    parity_ok = ^{word, par};
  endfunction

  typedef struct packed {
    logic        exception;
    logic        end_of_block;
    logic        stop;
    logic        busy;
    logic [15:0] read_data;
  } tfel_state_type;

  tfel_state_type state;
  tfel_state_type next_state;

  logic        write_try;
  logic        access;
  logic        reg_exists;
  logic        exempt;
  logic        ctrl_par_bad;
  logic        refuse;
  logic        func_go;
  logic        drive_clear;
  logic        bad_func;
  logic        bad_format;
  logic        clear_all;
  logic        class_a_hit;
  logic        class_b_hit;
  logic [15:0] set_bits;

  // -----------------------------------------------------------------
  // register access checks
  // -----------------------------------------------------------------
  always_comb begin
    write_try    = reg_write & drive_selected;
    access       = (reg_write | reg_read) & drive_selected;
    reg_exists   = EXIST_MASK[reg_addr];
    exempt       = (reg_addr == tfel_pkg::REG_MAINT) | (reg_addr == tfel_pkg::REG_ATTN);
    ctrl_par_bad = write_try & ~parity_ok(reg_wdata, reg_wparity);
    // refusal applies to the control register too, so drive clear needs an idle drive
    refuse       = write_try & reg_exists & state.busy & ~exempt;
    reg_write_accept = write_try & reg_exists & ~ctrl_par_bad & ~refuse;
    func_go      = reg_write_accept & (reg_addr == tfel_pkg::REG_CONTROL)
                   & reg_wdata[tfel_pkg::GO_BIT];
    drive_clear  = func_go & (reg_wdata[5:0] == tfel_pkg::FUNC_DRIVE_CLEAR);
    bad_func     = func_go & ~FUNC_MASK[reg_wdata[5:1]];
    bad_format   = transfer_start & ~FORMAT_MASK[format_code];
    clear_all    = drive_clear | controller_init;
  end

  // -----------------------------------------------------------------
  // error detection
  // -----------------------------------------------------------------
  always_comb begin
    set_bits = 16'h0000;
    set_bits[tfel_pkg::BIT_BAD_FUNCTION]  = bad_func;
    set_bits[tfel_pkg::BIT_BAD_REGISTER]  = access & ~reg_exists;
    set_bits[tfel_pkg::BIT_WRITE_REFUSED] = refuse;
    set_bits[tfel_pkg::BIT_CTRL_PARITY]   = ctrl_par_bad;
    set_bits[tfel_pkg::BIT_BAD_FORMAT]    = bad_format;
    // data still goes to tape; the flag and a class A exception record the fault
    set_bits[tfel_pkg::BIT_DATA_PARITY]   = data_valid & write_mode
                                            & ~parity_ok(data_word, data_parity);
    set_bits[tfel_pkg::BIT_UNCORR_VPE]    = pe_mode ? uncorrectable_event
                                            : (vertical_parity_event | late_data_event);
    set_bits[tfel_pkg::BIT_PREAMBLE_LRC]  = pe_mode ? preamble_error_event
                                            : (lrc_check & (longitudinal_check_character
                                               != computed_check_character));
    set_bits[tfel_pkg::BIT_GAP_VIOLATION] = gap_char_event & shutdown_first_half;
    set_bits[tfel_pkg::BIT_FRAME_COUNT]   = (space_end & frame_count_nonzero)
                                            | (frame_count_overflow & write_mode
                                               & ~word_count_overflowed)
                                            | (record_end & ~write_mode
                                               & ~word_count_overflowed);
    class_b_hit = |(set_bits & tfel_pkg::CLASS_B_MASK);
    class_a_hit = |(set_bits & ~tfel_pkg::CLASS_B_MASK);
  end

  tfel_flag_bank #(
    .WIDTH     (tfel_pkg::ERR_W)
  ) u_flags (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .set_bits  (set_bits),
    .clear_all (clear_all),
    .flags     (error_flags)
  );

  // -----------------------------------------------------------------
  // classing and reporting state
  // -----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (clear_all | func_go) begin
      next_state.exception    = clear_all ? 1'b0 : state.exception;
      next_state.end_of_block = 1'b0;
      next_state.stop         = 1'b0;
    end
    if (func_go & ~bad_func & ~drive_clear) begin
      next_state.busy = 1'b1;
    end else if (op_done | clear_all) begin
      next_state.busy = 1'b0;
    end
    if (block_end & state.busy) begin
      next_state.end_of_block = 1'b1;
    end
    if (class_a_hit) begin
      next_state.exception = 1'b1;
    end
    if (class_b_hit) begin
      next_state.exception    = 1'b1;
      next_state.end_of_block = 1'b1;
      next_state.stop         = 1'b1;
      next_state.busy         = 1'b0;
    end
    if (reg_read & drive_selected & (reg_addr == tfel_pkg::REG_ERROR)) begin
      next_state.read_data = error_flags;
    end else if (reg_read & drive_selected) begin
      next_state.read_data = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign exception_signal    = state.exception;
  assign end_of_block_signal = state.end_of_block;
  assign stop_transfer       = state.stop;
  assign operation_busy      = state.busy;
  assign reg_rdata           = state.read_data;
  assign drive_status_error  = |error_flags;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence class_b_response;
    stop_transfer && end_of_block_signal && exception_signal;
  endsequence

  sequence class_a_response;
    exception_signal && !stop_transfer;
  endsequence

  class_b_stop_a: assert property (
    class_b_hit |=> class_b_response)
    else $error("class B error did not stop the transfer");
  class_a_exc_a: assert property (
    class_a_hit && !class_b_hit && !stop_transfer && !clear_all && !func_go
    |=> class_a_response)
    else $error("class A error did not raise exception alone");
  block_end_eob_a: assert property (
    block_end && operation_busy |=> end_of_block_signal)
    else $error("end of block missing at block end");
  bad_func_a: assert property (
    bad_func |=> error_flags[tfel_pkg::BIT_BAD_FUNCTION] ##0 class_b_response)
    else $error("bad function not flagged as class B");
  bad_reg_a: assert property (
    access && !reg_exists |-> !reg_write_accept ##1 error_flags[tfel_pkg::BIT_BAD_REGISTER])
    else $error("missing register not flagged");
  refuse_write_a: assert property (
    refuse |-> !reg_write_accept ##1 error_flags[tfel_pkg::BIT_WRITE_REFUSED])
    else $error("write during go not refused");
  ctrl_parity_a: assert property (
    ctrl_par_bad |-> !reg_write_accept ##1 error_flags[tfel_pkg::BIT_CTRL_PARITY])
    else $error("control parity error not flagged");
  bad_format_a: assert property (
    bad_format |=> error_flags[tfel_pkg::BIT_BAD_FORMAT] && stop_transfer)
    else $error("bad format not flagged as class B");
  gap_flag_a: assert property (
    gap_char_event && shutdown_first_half |=> error_flags[tfel_pkg::BIT_GAP_VIOLATION])
    else $error("gap violation not flagged");
  frame_space_a: assert property (
    space_end && frame_count_nonzero |=> error_flags[tfel_pkg::BIT_FRAME_COUNT])
    else $error("frame count mismatch not flagged");
  drive_clear_a: assert property (
    drive_clear && set_bits == 16'h0000
    |=> error_flags == 16'h0000 && !exception_signal)
    else $error("drive clear left errors");
  composite_err_a: assert property (
    set_bits != 16'h0000 |=> drive_status_error)
    else $error("composite error bit missing after an error");
  err_quiet_a: assert property (
    !drive_status_error && set_bits == 16'h0000 |=> !drive_status_error)
    else $error("composite error bit raised with no error");
  sticky_bits_a: assert property (
    !clear_all |=> (error_flags & $past(error_flags)) == $past(error_flags))
    else $error("error bit dropped without clear");
endmodule
`default_nettype wire

// File: hw/tfel_pkg.sv
// Purpose: shared constants for the tape formatter error logic
// Assumes: one drive, one formatter clock, synchronous active-high reset
// Notes:   error bit positions, error classes, register indices, function codes
package tfel_pkg;
  // -----------------------------------------------------------------
  // error register layout
  // -----------------------------------------------------------------
  localparam int unsigned ERR_W             = 16;
  localparam int unsigned BIT_BAD_FUNCTION  = 0;
  localparam int unsigned BIT_BAD_REGISTER  = 1;
  localparam int unsigned BIT_WRITE_REFUSED = 2;
  localparam int unsigned BIT_CTRL_PARITY   = 3;
  localparam int unsigned BIT_BAD_FORMAT    = 4;
  localparam int unsigned BIT_DATA_PARITY   = 5;
  localparam int unsigned BIT_UNCORR_VPE    = 6;
  localparam int unsigned BIT_PREAMBLE_LRC  = 7;
  localparam int unsigned BIT_GAP_VIOLATION = 8;
  localparam int unsigned BIT_FRAME_COUNT   = 9;
  localparam logic [15:0] CLASS_B_MASK      = 16'h0011;
  localparam logic [15:0] FLAGS_RESET       = 16'h0000;
  localparam int unsigned STATUS_ERROR_BIT  = 14;
  // -----------------------------------------------------------------
  // register indices on the drive register port
  // -----------------------------------------------------------------
  localparam int unsigned ADDR_W            = 5;
  localparam logic [4:0]  REG_CONTROL       = 5'h00;
  localparam logic [4:0]  REG_ERROR         = 5'h02;
  localparam logic [4:0]  REG_MAINT         = 5'h03;
  localparam logic [4:0]  REG_ATTN          = 5'h04;
  localparam logic [31:0] REG_EXIST_MASK    = 32'h0000_0fff;
  // -----------------------------------------------------------------
  // function codes, go bit included in bit 0
  // -----------------------------------------------------------------
  localparam int unsigned GO_BIT            = 0;
  localparam logic [5:0]  FUNC_DRIVE_CLEAR  = 6'h09;
  localparam logic [31:0] FUNC_VALID_MASK   = 32'h1100_0819;
  localparam logic [15:0] FORMAT_VALID_MASK = 16'h0007;
endpackage

// File: hw/tfel_flag_bank.sv
// Purpose: sticky error flag bank
// Assumes: set and clear are single-cycle pulses on clk_sys
// Notes:   a set arriving with the clear survives it
`timescale 1ns/1ps
`default_nettype none
module tfel_flag_bank #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // control
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             clear_all,
  // state
  output logic      [WIDTH-1:0] flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } tfel_bank_type;

  tfel_bank_type state;
  tfel_bank_type next_state;

  always_comb begin
    next_state = state;
    if (clear_all) begin
      next_state.flags = set_bits;
    end else begin
      next_state.flags = state.flags | set_bits;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state.flags <= WIDTH'(tfel_pkg::FLAGS_RESET);
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
endmodule
`default_nettype wire

// File: test/tfel_host_model.sv
// Purpose: host controller model on the drive register port
// Assumes: one request at a time, each strobe held for one edge
// Notes:   released lines show inverted values and the drive is deselected
`timescale 1ns/1ps
`default_nettype none
module tfel_host_model (
  // clock
  input  wire logic   clk_sys,
  // drive register port
  output logic        drive_selected,
  output logic [4:0]  reg_addr,
  output logic        reg_read,
  output logic        reg_write,
  output logic [15:0] reg_wdata,
  output logic        reg_wparity
);
  initial begin
    drive_selected = 1'b0;
    reg_addr = 5'h00;
    reg_read = 1'b0;
    reg_write = 1'b0;
    reg_wdata = 16'h0000;
    reg_wparity = 1'b0;
  end
  // -----------------------------------------------------------------
  // bus cycles
  // -----------------------------------------------------------------
  // stale lines must never look like the last request
  task automatic idle();
    drive_selected <= 1'b0;
    reg_read <= 1'b0;
    reg_write <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
    reg_wparity <= ~reg_wparity;
  endtask
  // odd parity over data and parity bit; bad flips it
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input bit bad, input bit sel);
    @(posedge clk_sys);
    drive_selected <= sel;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wparity <= ~(^d) ^ bad;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    idle();
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    drive_selected <= 1'b1;
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    idle();
  endtask
  task automatic clr(input bit sel);
    wr(5'h00, {10'h000, tfel_pkg::FUNC_DRIVE_CLEAR}, 1'b0, sel);
  endtask
endmodule
`default_nettype wire

// File: test/tfel_error_logic_tb.sv
// Purpose: self-checking bench for the tape formatter error logic
// Assumes: host model drives the register port, bench drives the datapath
// Notes:   expected results are queued by the driver, popped by a monitor
`timescale 1ns/1ps
`default_nettype none
module tfel_error_logic_tb;
  logic clk_sys, drive_selected, reg_read, reg_write, reg_wparity, reg_write_accept;
  logic reset = 1'b1;
  logic controller_init = 1'b0;
  logic write_mode = 1'b0;
  logic pe_mode = 1'b0;
  logic data_parity = 1'b0;
  logic shutdown_first_half = 1'b0;
  logic frame_count_nonzero = 1'b0;
  logic word_count_overflowed = 1'b0;
  logic [3:0] format_code = 4'h0;
  logic [7:0] lcc_tape = 8'h00;
  logic [7:0] lcc_calc = 8'h00;
  logic [15:0] dword = 16'h0000;
  logic [12:0] ev = 13'h0000;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, error_flags, rv;
  logic exception_signal, end_of_block_signal, stop_transfer, operation_busy;
  logic drive_status_error, e1, v;
  logic rd_p = 1'b0;
  logic [36:0] e37;
  logic acc_q[$];
  logic [36:0] rd_q[$];
  logic [31:0] seed = 32'h0001_3b23;
  int unsigned bpos [11] = '{4, 5, 6, 6, 6, 7, 7, 8, 9, 9, 9};
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  tfel_host_model host (.clk_sys, .drive_selected, .reg_addr, .reg_read, .reg_write,
    .reg_wdata, .reg_wparity);
  tfel_error_logic DUT (.clk_sys, .reset, .controller_init, .drive_selected, .reg_addr,
    .reg_read, .reg_write, .reg_wdata, .reg_wparity, .reg_write_accept, .reg_rdata,
    .transfer_start(ev[0]), .format_code, .write_mode, .block_end(ev[11]),
    .op_done(ev[12]), .data_valid(ev[1]), .data_word(dword), .data_parity, .pe_mode,
    .uncorrectable_event(ev[2]), .vertical_parity_event(ev[3]), .late_data_event(ev[4]),
    .preamble_error_event(ev[5]), .lrc_check(ev[6]), .longitudinal_check_character(lcc_tape),
    .computed_check_character(lcc_calc), .gap_char_event(ev[7]), .shutdown_first_half,
    .space_end(ev[8]), .frame_count_nonzero, .frame_count_overflow(ev[9]),
    .word_count_overflowed, .record_end(ev[10]), .exception_signal, .end_of_block_signal,
    .stop_transfer, .operation_busy, .error_flags, .drive_status_error);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk_bit(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chk_vec(input string n, input logic [20:0] e, input logic [20:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // acc is the accept level expected while this write stands
  task automatic w(input logic [4:0] a, input logic [15:0] d, input bit bad, input logic acc);
    acc_q.push_back(acc);
    host.wr(a, d, bad, 1'b1);
  endtask
  // s is {busy, exception, end of block, stop}
  task automatic r(input logic [4:0] a, input logic [15:0] rd, input logic [3:0] s,
                   input logic [15:0] f);
    rd_q.push_back({rd, s, |f, f});
    host.rd(a);
  endtask
  task automatic rf(input logic [3:0] s, input logic [15:0] f);
    r(5'h02, f, s, f);
  endtask
  task automatic dclr(input bit sel);
    if (sel)
      acc_q.push_back(1'b1);
    host.clr(sel);
  endtask
  task automatic pul(input int k);
    @(posedge clk_sys);
    ev <= 13'h0001 << k;
    @(posedge clk_sys);
    ev <= 13'h0000;
  endtask
  task automatic ini();
    @(posedge clk_sys);
    controller_init <= 1'b1;
    @(posedge clk_sys);
    controller_init <= 1'b0;
  endtask
  // bad=0 sets up the same event with its error condition absent, except events 2 to 5, which are errors whatever bad is
  task automatic fire(input int k, input bit bad);
    rv = rnd();
    @(posedge clk_sys);
    pe_mode <= (k == 2 || k == 5);
    write_mode <= (k == 1 || k == 9);
    format_code <= bad ? {1'b1, rv[10:8]} : {2'h0, rv[9] & ~rv[8], rv[8]};
    dword <= rv;
    data_parity <= ~(^rv) ^ bad;
    lcc_tape <= rv[7:0];
    lcc_calc <= rv[7:0] ^ {7'h00, bad};
    shutdown_first_half <= bad;
    frame_count_nonzero <= bad;
    word_count_overflowed <= ~bad;
    pul(k);
  endtask

  // -----------------------------------------------------------------
  // clock, monitor, timeout
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_p <= reg_read & drive_selected;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      finish_test();
    end
  end
  always @(negedge clk_sys) begin
    if (reg_write && drive_selected && acc_q.size() > 0) begin
      e1 = acc_q.pop_front();
      chk_bit("accept", e1, reg_write_accept);
    end
    if (rd_p && rd_q.size() > 0) begin
      e37 = rd_q.pop_front();
      chk_vec("status", e37[20:0], {operation_busy, exception_signal, end_of_block_signal,
              stop_transfer, drive_status_error, error_flags});
      chk_vec("rdata", {5'h00, e37[36:21]}, {5'h00, reg_rdata});
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rf(4'h0, 16'h0000);
    for (int c = 0; c < 32; c++) begin
      if (c == 4)
        continue;
      v = tfel_pkg::FUNC_VALID_MASK[c];
      w(5'h00, {10'h000, c[4:0], 1'b1}, 1'b0, 1'b1);
      rf({v, ~v, ~v, ~v}, {15'h0000, ~v});
      pul(12);
      ini();
    end
    for (int k = 0; k < 11; k++) begin
      fire(k, 1'b1);
      rf({2'b01, {2{k == 0}}}, 16'h0001 << bpos[k]);
      if (k[0])
        dclr(1'b1);
      else
        ini();
      if (k inside {0, 1, 6, 7, 8, 9, 10}) begin
        fire(k, 1'b0);
        rf(4'h0, 16'h0000);
      end
    end
    fire(0, 1'b1);
    dclr(1'b0);
    rf(4'b0111, 16'h0010);
    dclr(1'b1);
    rf(4'h0, 16'h0000);
    r(5'h0c, 16'h0000, 4'b0100, 16'h0002);
    w(5'h1f, rnd(), 1'b0, 1'b0);
    rf(4'b0100, 16'h0002);
    ini();
    rv = rnd();
    w(5'h00, 16'h0031, 1'b0, 1'b1);
    w(5'h05, rv, 1'b0, 1'b0);
    w(5'h03, rv, 1'b0, 1'b1);
    w(5'h04, rv, 1'b0, 1'b1);
    w(5'h03, rv, 1'b1, 1'b0);
    w(5'h00, 16'h0009, 1'b0, 1'b0);
    rf(4'b1100, 16'h000c);
    fire(3, 1'b1);
    rf(4'b1100, 16'h004c);
    pul(11);
    rf(4'b1110, 16'h004c);
    pul(12);
    rf(4'b0110, 16'h004c);
    ini();
    rf(4'h0, 16'h0000);
    repeat (4) @(posedge clk_sys);
    finish_test();
  end
endmodule
`default_nettype wire
